// ---- rwd_pkg.sv ----
// constants shared by the ring insertion watchdog block
package rwd_pkg;

  // ==========================================================
  // register map
  localparam logic [3:0] RWD_OFF_CTRL = 4'h0;
  localparam logic [3:0] RWD_OFF_STATUS = 4'h4;
  localparam logic [3:0] RWD_OFF_WDOG_LEFT = 4'h8;

  // control fields
  localparam int RWD_CTRL_INHIBIT_BIT = 0;
  localparam logic RWD_CTRL_INHIBIT_RST = 1'b0;

  // status fields
  localparam int RWD_STAT_PHANTOM_BIT = 0;
  localparam int RWD_STAT_EXPIRED_BIT = 1;
  localparam int RWD_STAT_FAULT_BIT = 2;
  localparam int RWD_STAT_FREQ_BIT = 3;
  localparam int RWD_STAT_BYPASS_BIT = 4;
  localparam logic RWD_FAULT_STICKY_RST = 1'b0;

  // ==========================================================
  // timing
  localparam longint RWD_CLK_HZ = 100000000;
  localparam longint RWD_CLK_NS = 10;
  localparam longint RWD_WDOG_MIN_MS = 21;
  localparam longint RWD_WDOG_MAX_MS = 50;
  localparam longint RWD_WDOG_NOM_MS = 35;
  localparam longint RWD_WDOG_CYCLES = RWD_WDOG_NOM_MS * RWD_CLK_HZ / 1000;
  localparam int RWD_WDOG_W = 24;
  localparam longint RWD_DOWN_NS = 20;
  localparam int RWD_DOWN_CYCLES = int'((RWD_DOWN_NS + RWD_CLK_NS - 1) / RWD_CLK_NS);
  localparam int RWD_DIV_W = 3;
  localparam int RWD_SYNC_N = 13;
  localparam logic [1:0] RWD_STRAP_WAIT = 2'h3;

  // ==========================================================
  // detector sequence
  typedef enum logic [1:0] {RWD_PD_IDLE, RWD_PD_UP, RWD_PD_DOWN} rwd_pd_state_t;

endpackage

// ---- rwd_detector.sv ----
// phase and frequency detector feeding the charge pump controls
module rwd_detector
  import rwd_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic freq_mode,
  input wire logic data_edge,
  input wire logic rclk_rise,
  input wire logic ref_rise,
  output logic pump_up_q,
  output logic pump_down_q
);

  // ==========================================================
  // phase mode sequencer
  rwd_pd_state_t state_q;
  rwd_pd_state_t state_d;
  logic [1:0] down_cnt_q;
  logic [1:0] down_cnt_d;
  logic up_d;
  logic down_d;
  wire down_last = (down_cnt_q == 2'(RWD_DOWN_CYCLES - 1));
  wire freq_up = ref_rise & ~rclk_rise;
  wire freq_down = rclk_rise & ~ref_rise;

  always_comb begin
    state_d = state_q;
    down_cnt_d = down_cnt_q;
    unique case (state_q)
      // up width set by data to clock
      RWD_PD_IDLE: begin
        if (data_edge & ~freq_mode) begin
          state_d = RWD_PD_UP;
        end
      end
      RWD_PD_UP: begin
        if (rclk_rise | freq_mode) begin
          state_d = RWD_PD_DOWN;
          down_cnt_d = 2'h0;
        end
      end
      RWD_PD_DOWN: begin
        down_cnt_d = down_cnt_q + 2'h1;
        if (down_last) begin
          state_d = RWD_PD_IDLE;
        end
      end
    endcase
  end

  // mode picks which detector drives pump
  // up and down are mutually exclusive
  always_comb begin
    if (freq_mode) begin
      up_d = freq_up;
      down_d = freq_down;
    end else begin
      up_d = (state_d == RWD_PD_UP);
      down_d = (state_d == RWD_PD_DOWN);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= RWD_PD_IDLE;
      down_cnt_q <= 2'h0;
      pump_up_q <= 1'b0;
      pump_down_q <= 1'b0;
    end else begin
      state_q <= state_d;
      down_cnt_q <= down_cnt_d;
      pump_up_q <= up_d;
      pump_down_q <= down_d;
    end
  end

endmodule

// ---- rwd_top.sv ----
// ring interface digital core: data latch, wrap, insertion watchdog, phantom control
module rwd_top
  import rwd_pkg::*;
#(
  parameter longint WDOG_CYCLES = RWD_WDOG_CYCLES
) (
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic [3:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  input wire logic RATE_SELECT,
  input wire logic DETECT_MODE_SELECT,
  input wire logic LOOPBACK_SELECT_N,
  input wire logic OUTPUT_ENABLE,
  input wire logic INSERT_REQUEST,
  input wire logic TIMER_CAP_PIN,
  input wire logic TRANSMIT_DATA_IN,
  input wire logic TRANSMIT_DATA_IN_N,
  input wire logic RX_LINE,
  input wire logic XTAL_REF,
  input wire logic [1:0] SENSE_SHORT,
  input wire logic [1:0] SENSE_OPEN,
  output logic LINE_DRIVE_A,
  output logic LINE_DRIVE_B,
  output logic RECOVERED_DATA,
  output logic RECOVERED_DATA_OE,
  output logic RECOVERED_CLOCK_OUT,
  output logic RECOVERED_CLOCK_OE,
  output logic PHANTOM_OUT_A,
  output logic PHANTOM_OUT_A_OE,
  output logic PHANTOM_OUT_B,
  output logic PHANTOM_OUT_B_OE,
  output logic PHANTOM_FAULT_N,
  output logic PHANTOM_FAULT_N_OE,
  output logic PUMP_UP,
  output logic PUMP_DOWN
);

  localparam logic [RWD_WDOG_W-1:0] WDOG_LOAD = RWD_WDOG_W'(WDOG_CYCLES);

  // ==========================================================
  // pin synchronisers
  wire [RWD_SYNC_N-1:0] pin_raw = {RATE_SELECT, DETECT_MODE_SELECT, LOOPBACK_SELECT_N,
                                   OUTPUT_ENABLE, INSERT_REQUEST, TIMER_CAP_PIN,
                                   TRANSMIT_DATA_IN, RX_LINE, XTAL_REF,
                                   SENSE_SHORT, SENSE_OPEN};
  logic [RWD_SYNC_N-1:0] sync1_q;
  logic [RWD_SYNC_N-1:0] sync2_q;

  genvar gi;
  generate
    for (gi = 0; gi < RWD_SYNC_N; gi++) begin : g_sync
      always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  wire rate_s = sync2_q[12];
  wire freq_mode_s = sync2_q[11];
  wire wrap_n_s = sync2_q[10];
  wire enable_s = sync2_q[9];
  wire insert_s = sync2_q[8];
  wire strap_s = sync2_q[7];
  wire tx_s = sync2_q[6];
  wire rx_s = sync2_q[5];
  wire xtal_s = sync2_q[4];
  wire [1:0] short_s = sync2_q[3:2];
  wire [1:0] open_s = sync2_q[1:0];

  // ==========================================================
  // transmit steering
  // unretimed: skew between the pair passes straight to the line
  assign LINE_DRIVE_A = TRANSMIT_DATA_IN & ~TRANSMIT_DATA_IN_N & LOOPBACK_SELECT_N;
  assign LINE_DRIVE_B = ~TRANSMIT_DATA_IN & TRANSMIT_DATA_IN_N & LOOPBACK_SELECT_N;

  // ==========================================================
  // recovered clock and data latch
  logic [RWD_DIV_W-1:0] osc_cnt_q;
  logic rclk_q;
  logic rx_latch_q;
  logic rx_prev_q;
  logic xtal_prev_q;
  // bit 0 stands in for the oscillator, bit 2 is it divided by four
  // rate select high picks the slow ring
  wire rclk_d = rate_s ? osc_cnt_q[2] : osc_cnt_q[0];
  wire rclk_rise = rclk_d & ~rclk_q;
  wire rx_src = wrap_n_s ? rx_s : ~tx_s;
  wire data_edge = rx_src ^ rx_prev_q;
  wire ref_rise = xtal_s & ~xtal_prev_q;

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      osc_cnt_q <= '0;
      rclk_q <= 1'b0;
      rx_prev_q <= 1'b0;
      xtal_prev_q <= 1'b0;
    end else begin
      osc_cnt_q <= osc_cnt_q + RWD_DIV_W'(1);
      rclk_q <= rclk_d;
      rx_prev_q <= rx_src;
      xtal_prev_q <= xtal_s;
    end
  end

  // latch moves with the clock rise, so it holds a full period
  // host's next rising edge sees it stable
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_latch_q <= 1'b0;
    end else if (rclk_rise) begin
      rx_latch_q <= rx_src;
    end
  end

  // ==========================================================
  // strap capture after reset release
  logic [1:0] strap_wait_q;
  logic bypass_q;
  wire strap_take = (strap_wait_q == RWD_STRAP_WAIT - 2'h1);

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      strap_wait_q <= 2'h0;
      bypass_q <= 1'b0;
    end else begin
      if (strap_wait_q != RWD_STRAP_WAIT) begin
        strap_wait_q <= strap_wait_q + 2'h1;
      end
      if (strap_take) begin
        bypass_q <= strap_s;
      end
    end
  end

  // ==========================================================
  // watchdog
  logic insert_prev_q;
  logic [RWD_WDOG_W-1:0] wdog_q;
  logic [RWD_WDOG_W-1:0] wdog_d;
  wire insert_fall = insert_prev_q & ~insert_s;
  wire wdog_live = (wdog_q != '0);

  // counter reloaded on each falling edge while wrap is off
  // rising edge leaves count running down
  // no edges means it simply runs out
  always_comb begin
    wdog_d = wdog_q;
    if (insert_fall & wrap_n_s) begin
      wdog_d = WDOG_LOAD;
    end else if (wdog_live) begin
      wdog_d = wdog_q - RWD_WDOG_W'(1);
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      insert_prev_q <= 1'b0;
      wdog_q <= '0;
    end else begin
      insert_prev_q <= insert_s;
      wdog_q <= wdog_d;
    end
  end

  // ==========================================================
  // register file
  logic inhibit_q;
  logic fault_sticky_q;
  logic [31:0] rdata_q;
  wire sel_ctrl = (REG_ADDR == RWD_OFF_CTRL);
  wire sel_status = (REG_ADDR == RWD_OFF_STATUS);
  wire sel_left = (REG_ADDR == RWD_OFF_WDOG_LEFT);
  wire wr_ctrl = REG_WR & sel_ctrl;
  wire clr_fault = REG_WR & sel_status & REG_WDATA[RWD_STAT_FAULT_BIT];

  // ==========================================================
  // phantom drive and fault
  logic phantom_q;
  logic fault_n_q;
  // strapped off: insert low means inserted, no timeout
  // expiry drops drive whatever the wrap level
  // wrap holds drive off, live count may resume it
  // count default sits inside the 21 to 50 ms window
  wire phantom_d = ~inhibit_q & wrap_n_s & (bypass_q ? ~insert_s : wdog_live);
  // any short or open pulls fault low while insert is low
  wire fault_hit = |{short_s, open_s};
  wire fault_n_d = insert_s | ~fault_hit;

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      phantom_q <= 1'b0;
      fault_n_q <= 1'b1;
    end else begin
      phantom_q <= phantom_d;
      fault_n_q <= fault_n_d;
    end
  end

  // ==========================================================
  // register access
  // inhibit lets software drop the drive without touching insert
  logic [31:0] rd_mux;
  assign rd_mux = sel_ctrl ? {31'h0, inhibit_q} :
                  sel_status ? {27'h0, bypass_q, freq_mode_s, fault_sticky_q,
                                ~wdog_live & ~bypass_q, phantom_q} :
                  sel_left ? {8'h0, wdog_q} : 32'h0;

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      inhibit_q <= RWD_CTRL_INHIBIT_RST;
      fault_sticky_q <= RWD_FAULT_STICKY_RST;
      rdata_q <= 32'h0;
    end else begin
      if (wr_ctrl) begin
        inhibit_q <= REG_WDATA[RWD_CTRL_INHIBIT_BIT];
      end
      // set wins over a same-cycle clear
      if (~fault_n_d) begin
        fault_sticky_q <= 1'b1;
      end else if (clr_fault) begin
        fault_sticky_q <= 1'b0;
      end
      rdata_q <= REG_RD ? rd_mux : 32'h0;
    end
  end

  // ==========================================================
  // detectors
  logic pump_up_q;
  logic pump_down_q;

  // in phase mode, a data transition seen in idle opens one sequence
  rwd_detector u_det (
    .clk(MCLK),
    .arst_n(ARST_N),
    .freq_mode(freq_mode_s),
    .data_edge(data_edge),
    .rclk_rise(rclk_rise),
    .ref_rise(ref_rise),
    .pump_up_q(pump_up_q),
    .pump_down_q(pump_down_q)
  );

  // ==========================================================
  // output stage
  logic enable_q;
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      enable_q <= 1'b0;
    end else begin
      enable_q <= enable_s;
    end
  end

  // enable low floats phantom and fault pins
  assign PHANTOM_OUT_A_OE = enable_q;
  assign PHANTOM_OUT_B_OE = enable_q;
  assign PHANTOM_FAULT_N_OE = enable_q;
  assign RECOVERED_DATA_OE = enable_q;
  assign RECOVERED_CLOCK_OE = enable_q;
  assign PHANTOM_OUT_A = phantom_q;
  assign PHANTOM_OUT_B = phantom_q;
  assign PHANTOM_FAULT_N = fault_n_q;
  assign RECOVERED_DATA = rx_latch_q;
  assign RECOVERED_CLOCK_OUT = rclk_q;
  assign REG_RDATA = rdata_q;
  assign PUMP_UP = pump_up_q;
  assign PUMP_DOWN = pump_down_q;

endmodule

// ---- rwd_monitor.sv ----
// port checker for the ring insertion watchdog core
module rwd_monitor #(
  parameter longint WDOG_CYCLES = 50
) (
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic RATE_SELECT,
  input wire logic DETECT_MODE_SELECT,
  input wire logic LOOPBACK_SELECT_N,
  input wire logic OUTPUT_ENABLE,
  input wire logic INSERT_REQUEST,
  input wire logic TIMER_CAP_PIN,
  input wire logic TRANSMIT_DATA_IN,
  input wire logic TRANSMIT_DATA_IN_N,
  input wire logic LINE_DRIVE_A,
  input wire logic LINE_DRIVE_B,
  input wire logic RECOVERED_DATA,
  input wire logic RECOVERED_CLOCK_OUT,
  input wire logic PHANTOM_OUT_A,
  input wire logic PHANTOM_OUT_A_OE,
  input wire logic PHANTOM_OUT_B,
  input wire logic PHANTOM_OUT_B_OE,
  input wire logic PHANTOM_FAULT_N,
  input wire logic PHANTOM_FAULT_N_OE,
  input wire logic PUMP_UP,
  input wire logic PUMP_DOWN
);
  longint idle_q;
  logic ins_q;
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (!ARST_N);
  // ========
  // cycles since the insert pin last fell, saturating
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      idle_q <= 0;
      ins_q <= 1'h1;
    end else begin
      ins_q <= INSERT_REQUEST;
      if (ins_q && !INSERT_REQUEST)
        idle_q <= 0;
      else if (idle_q < WDOG_CYCLES + 8)
        idle_q <= idle_q + 1;
    end
  end
  // ========
  // assertions
  a_drive_a_steer: assert property (LINE_DRIVE_A ==
    (TRANSMIT_DATA_IN && !TRANSMIT_DATA_IN_N && LOOPBACK_SELECT_N)) else $error("drive a wrong");
  a_drive_b_steer: assert property (LINE_DRIVE_B ==
    (!TRANSMIT_DATA_IN && TRANSMIT_DATA_IN_N && LOOPBACK_SELECT_N)) else $error("drive b wrong");
  a_pump_excl: assert property (!(PUMP_UP && PUMP_DOWN))
    else $error("up and down together");
  a_up_then_down: assert property ($fell(PUMP_UP) && !DETECT_MODE_SELECT &&
    !$past(DETECT_MODE_SELECT, 4) |-> PUMP_DOWN) else $error("up not followed by down");
  a_down_width: assert property ($rose(PUMP_DOWN) && !DETECT_MODE_SELECT &&
    !$past(DETECT_MODE_SELECT, 4) |=> PUMP_DOWN ##1 !PUMP_DOWN) else $error("down width");
  a_fault_high: assert property (INSERT_REQUEST [*3] |=> PHANTOM_FAULT_N)
    else $error("fault low while insert high");
  a_float_off: assert property (!OUTPUT_ENABLE [*4] |-> !PHANTOM_OUT_A_OE &&
    !PHANTOM_OUT_B_OE && !PHANTOM_FAULT_N_OE) else $error("phantom pins driven");
  a_wrap_off: assert property (!LOOPBACK_SELECT_N [*4] |-> !PHANTOM_OUT_A)
    else $error("phantom on in wrap");
  a_phantom_pair: assert property (PHANTOM_OUT_A == PHANTOM_OUT_B)
    else $error("phantom outputs differ");
  a_wdog_expiry: assert property (idle_q == WDOG_CYCLES + 8 && !TIMER_CAP_PIN
    |-> !PHANTOM_OUT_A) else $error("watchdog did not expire");
  // rate sync restarts at reset, so the divider is only trusted once settled
  a_clock_div: assert property (RATE_SELECT && $past(RATE_SELECT, 16) &&
    $past(ARST_N, 8) && $rose(RECOVERED_CLOCK_OUT) |->
    RECOVERED_CLOCK_OUT [*4] ##1 !RECOVERED_CLOCK_OUT)
    else $error("divided clock wrong");
  a_clock_fast: assert property (!RATE_SELECT && !$past(RATE_SELECT, 16) &&
    $past(ARST_N, 8) && $rose(RECOVERED_CLOCK_OUT) |=>
    !RECOVERED_CLOCK_OUT ##1 RECOVERED_CLOCK_OUT)
    else $error("undivided clock wrong");
  a_data_stable: assert property (!$rose(RECOVERED_CLOCK_OUT) |->
    $stable(RECOVERED_DATA)) else $error("data moved off clock rise");
  c_insert: cover property ($rose(PHANTOM_OUT_A));
  c_fault: cover property ($fell(PHANTOM_FAULT_N));
  c_down: cover property ($rose(PUMP_DOWN) && !DETECT_MODE_SELECT);
endmodule

bind rwd_top rwd_monitor #(.WDOG_CYCLES(WDOG_CYCLES)) i_rwd_monitor (.*);

// ---- rwd_media.sv ----
// trunk coupler and ring model facing the line and phantom pins
module rwd_media (
  input wire logic phantom,
  input wire logic phantom_oe,
  input wire logic drive_a,
  input wire logic ring_bit,
  input wire logic short_gnd,
  input wire logic open_wire,
  output logic rx_line,
  output logic [1:0] sense_short,
  output logic [1:0] sense_open
);
  // ========
  // coupler relay: uninserted, the coupler wraps transmit back
  assign rx_line = (phantom && phantom_oe) ? ring_bit : drive_a;
  // short on wire a, open on wire b
  assign sense_short = {1'h0, short_gnd};
  assign sense_open = {open_wire, 1'h0};
endmodule

// ---- test_ring_insertion_watchdog.sv ----
// self-checking bench for the ring insertion watchdog core
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin miscompares++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module test_ring_insertion_watchdog
  import rwd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam longint WD = 50;
  logic MCLK = 1'h0, ARST_N = 1'h0, REG_WR = 1'h0, REG_RD = 1'h0, RATE_SELECT = 1'h0;
  logic DETECT_MODE_SELECT = 1'h0, LOOPBACK_SELECT_N = 1'h1, OUTPUT_ENABLE = 1'h1;
  logic INSERT_REQUEST = 1'h1, TIMER_CAP_PIN = 1'h0;
  logic TRANSMIT_DATA_IN = 1'h0, TRANSMIT_DATA_IN_N = 1'h1;
  logic [3:0] REG_ADDR = 4'h0;
  logic [31:0] REG_WDATA = 32'h0, d;
  logic [1:0] xc = 2'h0;
  logic [2:0] r;
  logic gnd = 1'h0, cut = 1'h0, ring = 1'h0;
  wire XTAL_REF = xc[1];
  wire RX_LINE, LINE_DRIVE_A, LINE_DRIVE_B, RECOVERED_DATA, RECOVERED_DATA_OE;
  wire RECOVERED_CLOCK_OUT, RECOVERED_CLOCK_OE, PHANTOM_OUT_A, PHANTOM_OUT_A_OE;
  wire PHANTOM_OUT_B, PHANTOM_OUT_B_OE, PHANTOM_FAULT_N, PHANTOM_FAULT_N_OE, PUMP_UP, PUMP_DOWN;
  wire [1:0] SENSE_SHORT, SENSE_OPEN;
  wire [31:0] REG_RDATA;
  wire [4:0] oe_all = {PHANTOM_OUT_A_OE, PHANTOM_OUT_B_OE, PHANTOM_FAULT_N_OE,
                       RECOVERED_DATA_OE, RECOVERED_CLOCK_OE};
  int compares = 0, miscompares = 0, m_left = 0;
  bit m_ins = 1'h1, byp = 1'h0, inh = 1'h0;

  rwd_top #(.WDOG_CYCLES(WD)) i_rwd_top (.*);
  rwd_media i_rwd_media (
    .phantom(PHANTOM_OUT_A),
    .phantom_oe(PHANTOM_OUT_A_OE),
    .drive_a(LINE_DRIVE_A),
    .ring_bit(ring),
    .short_gnd(gnd),
    .open_wire(cut),
    .rx_line(RX_LINE),
    .sense_short(SENSE_SHORT),
    .sense_open(SENSE_OPEN)
  );

  initial forever #5 MCLK = ~MCLK;
  always @(posedge MCLK) xc <= xc + 2'h1;
  // ========
  // reference model; it sees pins without sync delay, so checks keep a margin
  always @(posedge MCLK) begin
    if (!ARST_N) m_left = 0;
    else if (m_ins && !INSERT_REQUEST && LOOPBACK_SELECT_N) m_left = int'(WD);
    else if (m_left > 0) m_left--;
    m_ins = INSERT_REQUEST;
  end
  function automatic logic m_ph();
    return !inh && LOOPBACK_SELECT_N && (byp ? !INSERT_REQUEST : m_left > 0);
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge MCLK);
  endtask
  task automatic chk(string n);
    @(negedge MCLK);
    `CHK(n, m_ph(), PHANTOM_OUT_A)
    `CHK(n, INSERT_REQUEST | ~(gnd | cut), PHANTOM_FAULT_N)
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] v);
    @(posedge MCLK);
    REG_WR <= 1'h1;
    REG_ADDR <= a;
    REG_WDATA <= v;
    @(posedge MCLK);
    REG_WR <= 1'h0;
  endtask
  task automatic rd(logic [3:0] a);
    @(posedge MCLK);
    REG_RD <= 1'h1;
    REG_ADDR <= a;
    @(posedge MCLK);
    REG_RD <= 1'h0;
    @(negedge MCLK);
    d = REG_RDATA;
  endtask
  // host side edges on the insert pin
  task automatic pin(logic v);
    @(posedge MCLK);
    INSERT_REQUEST <= v;
  endtask
  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (compares > 0 && miscompares == 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #30000;
    miscompares++;
    stop_test();
  end

  // ========
  // tests
  initial begin
    void'($urandom(32'h807e));
    tick(8);
    ARST_N <= 1'h1;
    chk("reset");
    wr(4'hc, 32'hffffffff);
    rd(RWD_OFF_CTRL);
    `CHK("ctrl", 32'h0, d)
    rd(4'hc);
    `CHK("unmapped", 32'h0, d)
    $display("end reset");
    for (int i = 0; i < 16; i++) begin
      @(posedge MCLK);
      TRANSMIT_DATA_IN <= i[0];
      TRANSMIT_DATA_IN_N <= i[1];
      LOOPBACK_SELECT_N <= i[2];
      OUTPUT_ENABLE <= i[3];
      @(negedge MCLK);
      `CHK("drive_a", i[0] & ~i[1] & i[2], LINE_DRIVE_A)
      `CHK("drive_b", ~i[0] & i[1] & i[2], LINE_DRIVE_B)
    end
    $display("end line drive");
    for (int i = 0; i < 8; i++) begin
      r = 3'($urandom());
      @(posedge MCLK);
      TRANSMIT_DATA_IN <= r[0];
      TRANSMIT_DATA_IN_N <= r[1];
      LOOPBACK_SELECT_N <= r[2];
      // host picks the slow ring on high
      RATE_SELECT <= i[2];
      tick(24);
      @(negedge MCLK);
      `CHK("rx_data", r[2] ? r[0] & ~r[1] : ~r[0], RECOVERED_DATA)
    end
    $display("end data");
    @(posedge MCLK);
    LOOPBACK_SELECT_N <= 1'h1;
    TRANSMIT_DATA_IN <= 1'h0;
    ring <= 1'h1;
    INSERT_REQUEST <= 1'h0;
    tick(8);
    chk("insert");
    pin(1'h1);
    tick(int'(WD) - 24);
    chk("rise_hold");
    `CHK("rx_ring", 1'h1, RECOVERED_DATA)
    tick(24);
    chk("stuck_high");
    rd(RWD_OFF_STATUS);
    `CHK("expired", 1'h1, d[RWD_STAT_EXPIRED_BIT])
    pin(1'h0);
    gnd <= 1'h1;
    tick(6);
    chk("short");
    @(posedge MCLK);
    gnd <= 1'h0;
    cut <= 1'h1;
    tick(int'(WD));
    chk("open_stuck_low");
    pin(1'h1);
    tick(6);
    chk("fault_masked");
    @(posedge MCLK);
    cut <= 1'h0;
    rd(RWD_OFF_STATUS);
    `CHK("sticky", 1'h1, d[RWD_STAT_FAULT_BIT])
    wr(RWD_OFF_STATUS, 32'h1 << RWD_STAT_FAULT_BIT);
    rd(RWD_OFF_STATUS);
    `CHK("cleared", 1'h0, d[RWD_STAT_FAULT_BIT])
    $display("end watchdog");
    pin(1'h0);
    tick(8);
    chk("wrap_pre");
    wr(RWD_OFF_CTRL, 32'h1);
    inh = 1'h1;
    rd(RWD_OFF_CTRL);
    `CHK("ctrl_set", 32'h1, d)
    chk("inhibit");
    wr(RWD_OFF_CTRL, 32'h0);
    inh = 1'h0;
    tick(2);
    chk("inhibit_off");
    for (int i = 0; i < 2; i++) begin
      @(posedge MCLK);
      LOOPBACK_SELECT_N <= i[0];
      tick(6);
      chk("wrap_toggle");
    end
    @(posedge MCLK);
    LOOPBACK_SELECT_N <= 1'h0;
    INSERT_REQUEST <= 1'h1;
    pin(1'h0);
    tick(int'(WD));
    @(posedge MCLK);
    LOOPBACK_SELECT_N <= 1'h1;
    tick(6);
    chk("wrap_expired");
    $display("end wrap");
    for (int i = 0; i < 2; i++) begin
      @(posedge MCLK);
      OUTPUT_ENABLE <= i[0];
      DETECT_MODE_SELECT <= ~i[0];
      tick(40);
      @(negedge MCLK);
      `CHK("oe", {5{i[0]}}, oe_all)
      rd(RWD_OFF_STATUS);
      `CHK("mode", ~i[0], d[RWD_STAT_FREQ_BIT])
    end
    $display("end enable and mode");
    @(posedge MCLK);
    ARST_N <= 1'h0;
    TIMER_CAP_PIN <= 1'h1;
    byp = 1'h1;
    tick(8);
    ARST_N <= 1'h1;
    INSERT_REQUEST <= 1'h0;
    tick(int'(WD) + 10);
    chk("bypass_on");
    rd(RWD_OFF_STATUS);
    `CHK("bypass", 1'h1, d[RWD_STAT_BYPASS_BIT])
    pin(1'h1);
    tick(6);
    chk("bypass_off");
    $display("end bypass");
    stop_test();
  end
endmodule
